// ===== design/amp_irq_and_audio_port_config.sv
// two-wire slave with interrupt and audio port configuration registers
// assumes: live status on sys_clk; scl and sda from pins, open-drain
//
// Summary of operation
// - any status change sets its flag
// - under-voltage flag also set at power-on
// - reading flags clears the returned bits
// - mask one blocks flag, zero passes
// - all mask bits reset to one
// - speaker gain code picks amplitude, reset six
// - earpiece gain code picks amplitude, reset zero
// - bit eight picks latched flags or status
// - bit nine picks open-drain or push-pull
// - bit six enables audio port
// - bit five swaps left and right
// - bit four inverts bit clock sense
// - bit three picks pll reference
// - bit one powers down amplifier, reset one
// - bit zero powers down system, reset one
// - bit thirteen attenuates input by 6 dB
// - channel pick left, right or average
// - frame format standard, msb or lsb justified
// - width code gives 16/20/24/32 bits
// - ratio code gives 32/48/64 clocks per frame
// - rate code selects sample rate, reset 48k
`timescale 1ns/1ps
`default_nettype none
`include "amp_cfg_map.svh"
module amp_irq_and_audio_port_config #(
    parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DFLT
) (
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    input  wire logic                       scl_in,
    input  wire logic                       sda_in,
    output logic                            sda_out,
    output logic                            sda_oe,
    input  wire logic [14:0]                live_status_reg,
    output logic                            irq_out_n,
    output logic                            irq_out_n_oe,
    output amp_cfg_pkg::system_control_t     system_control,
    output amp_cfg_pkg::audio_port_control_t audio_port_control,
    output logic [7:0]                      nominal_output_amplitude,
    output logic [6:0]                      bitclk_per_frame,
    output logic [5:0]                      word_length,
    output logic [13:0]                     sample_rate_10hz,
    output logic                            config_reserved
);
    import amp_cfg_pkg::*;

    // ************************************************
    // functions
    // ************************************************
    function automatic logic [7:0] amplitude(input system_control_t s);
        logic [7:0] a;
        if (s.earpiece_mode) begin
            case (s.earpiece_gain_sel)
                2'h0:    a = `AMP_4P5;
                2'h1:    a = `AMP_5;
                default: a = `AMP_5P5;
            endcase
        end else begin
            case (s.speaker_gain_sel)
                3'h0:    a = `AMP_7;
                3'h1:    a = `AMP_8;
                3'h2:    a = `AMP_10;
                3'h3:    a = `AMP_12;
                3'h4:    a = `AMP_14;
                3'h6:    a = `AMP_16;
                default: a = 8'h00;
            endcase
        end
        return a;
    endfunction

    function automatic logic [6:0] bck_ratio(input logic [1:0] c);
        logic [6:0] r;
        case (c)
            2'h0:    r = `BCK_32;
            2'h1:    r = `BCK_48;
            2'h2:    r = `BCK_64;
            default: r = 7'h00;
        endcase
        return r;
    endfunction

    function automatic logic [5:0] width_bits(input logic [1:0] c);
        logic [5:0] w;
        case (c)
            2'h0:    w = `WL_16;
            2'h1:    w = `WL_20;
            2'h2:    w = `WL_24;
            default: w = `WL_32;
        endcase
        return w;
    endfunction

    function automatic logic [13:0] rate(input logic [3:0] c);
        logic [13:0] f;
        case (c)
            4'h4:    f = `SR_22K05;
            4'h5:    f = `SR_24K;
            4'h6:    f = `SR_32K;
            4'h7:    f = `SR_44K1;
            4'h8:    f = `SR_48K;
            4'h9:    f = `SR_96K;
            default: f = 14'h0000;
        endcase
        return f;
    endfunction

    // ************************************************
    // pin synchronisers and bus events
    // ************************************************
    logic [1:0]  pins_l;
    logic        scl_l, sda_l, scl_prev_q, sda_prev_q, scl_rise, scl_fall, start_ev, stop_ev;

    pin_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin     ({scl_in, sda_in}),
        .level   (pins_l)
    );

    assign scl_l    = pins_l[1];
    assign sda_l    = pins_l[0];
    assign scl_rise = scl_l & ~scl_prev_q;
    assign scl_fall = ~scl_l & scl_prev_q;
    assign start_ev = scl_l & scl_prev_q & sda_prev_q & ~sda_l;
    assign stop_ev  = scl_l & scl_prev_q & ~sda_prev_q & sda_l;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_l;
            sda_prev_q <= sda_l;
        end
    end

    // ************************************************
    // interrupt flags
    // ************************************************
    logic [14:0] flags;
    logic        clr_en;
    logic [14:0] clr_mask;

    irq_flag_bank u_irq_flag_bank (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .status   (live_status_reg),
        .clr_en   (clr_en),
        .clr_mask (clr_mask),
        .flags    (flags)
    );

    // ************************************************
    // register file
    // ************************************************
    logic [15:0]         mask_q, mask_d, wr_data, rd_word;
    system_control_t     sys_q, sys_d;
    audio_port_control_t aud_q, aud_d;
    logic                wr_en;
    logic [7:0]          ptr_q;

    // fixed bits are forced on every write
    always_comb begin
        mask_d = mask_q;
        sys_d  = sys_q;
        aud_d  = aud_q;
        if (wr_en) begin
            case (ptr_q)
                `REG_MASKS:   mask_d = (wr_data & `MASK_WMASK) | `MASK_FIXED;
                `REG_SYSTEM_CONTROL: sys_d  = (wr_data & `SYS_WMASK) | `SYS_FIXED;
                `REG_AUDIO:   aud_d  = (wr_data & `AUD_WMASK) | `AUD_FIXED;
                default:      mask_d = mask_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mask_q <= `MASK_RESET;
            sys_q  <= `SYS_RESET;
            aud_q  <= `AUD_RESET;
        end else begin
            mask_q <= mask_d;
            sys_q  <= sys_d;
            aud_q  <= aud_d;
        end
    end

    // unmapped offsets read zero
    always_comb begin
        case (ptr_q)
            `REG_FLAGS:   rd_word = {1'b0, flags};
            `REG_MASKS:   rd_word = mask_q;
            `REG_SYSTEM_CONTROL: rd_word = sys_q;
            `REG_AUDIO:   rd_word = aud_q;
            default:      rd_word = 16'h0000;
        endcase
    end

    // ************************************************
    // two-wire slave
    // ************************************************
    link_state_t st_q, st_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [7:0]  shift_q, shift_d, ptr_d, hi_q, hi_d;
    logic        need_ptr_q, need_ptr_d, lo_q, lo_d, rw_q, rw_d, nack_q, nack_d;
    logic [15:0] word_q, word_d;
    logic        oe_q, oe_d, load_hi;

    always_comb begin
        st_d       = st_q;
        cnt_d      = cnt_q;
        shift_d    = shift_q;
        ptr_d      = ptr_q;
        hi_d       = hi_q;
        need_ptr_d = need_ptr_q;
        lo_d       = lo_q;
        rw_d       = rw_q;
        nack_d     = nack_q;
        word_d     = word_q;
        oe_d       = oe_q;
        load_hi    = 1'b0;
        wr_en      = 1'b0;
        wr_data    = {hi_q, shift_q};
        clr_en     = 1'b0;
        clr_mask   = rd_word[14:0];
        if (start_ev) begin
            st_d  = ST_ADDR;
            cnt_d = 4'h0;
            oe_d  = 1'b0;
        end else if (stop_ev) begin
            st_d = ST_IDLE;
            oe_d = 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    oe_d = 1'b0;
                end
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_l};
                        cnt_d   = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == `RX_LAST) begin
                        cnt_d = 4'h0;
                        if (st_q == ST_ADDR) begin
                            if (shift_q[7:1] == DEV_ADDR) begin
                                st_d       = ST_ADDR_ACK;
                                oe_d       = 1'b1;
                                rw_d       = shift_q[0];
                                need_ptr_d = ~shift_q[0];
                                lo_d       = 1'b0;
                            end else begin
                                st_d = ST_IDLE;
                            end
                        end else begin
                            st_d = ST_RX_ACK;
                            oe_d = 1'b1;
                            if (need_ptr_q) begin
                                ptr_d      = shift_q;
                                need_ptr_d = 1'b0;
                            end else if (!lo_q) begin
                                hi_d = shift_q;
                                lo_d = 1'b1;
                            end else begin
                                wr_en = 1'b1;
                                ptr_d = ptr_q + 8'h01;
                                lo_d  = 1'b0;
                            end
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            load_hi = 1'b1;
                        end else begin
                            st_d = ST_RX;
                            oe_d = 1'b0;
                        end
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        st_d = ST_RX;
                        oe_d = 1'b0;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_q == `TX_LAST) begin
                            st_d = ST_TX_ACK;
                            oe_d = 1'b0;
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                            cnt_d   = cnt_q + 4'h1;
                            oe_d    = ~shift_q[6];
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise) begin
                        nack_d = sda_l;
                    end else if (scl_fall) begin
                        if (nack_q) begin
                            st_d = ST_IDLE;
                        end else if (lo_q) begin
                            shift_d = word_q[7:0];
                            lo_d    = 1'b0;
                            cnt_d   = 4'h0;
                            st_d    = ST_TX;
                            oe_d    = ~word_q[7];
                        end else begin
                            load_hi = 1'b1;
                        end
                    end
                end
                default: begin
                    st_d = ST_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
        // whole word is latched so both bytes come from one snapshot
        if (load_hi) begin
            word_d  = rd_word;
            shift_d = rd_word[15:8];
            ptr_d   = ptr_q + 8'h01;
            lo_d    = 1'b1;
            cnt_d   = 4'h0;
            st_d    = ST_TX;
            oe_d    = ~rd_word[15];
            clr_en  = (ptr_q == `REG_FLAGS);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q       <= ST_IDLE;
            cnt_q      <= 4'h0;
            shift_q    <= 8'h00;
            ptr_q      <= 8'h00;
            hi_q       <= 8'h00;
            need_ptr_q <= 1'b0;
            lo_q       <= 1'b0;
            rw_q       <= 1'b0;
            nack_q     <= 1'b0;
            word_q     <= 16'h0000;
            oe_q       <= 1'b0;
        end else begin
            st_q       <= st_d;
            cnt_q      <= cnt_d;
            shift_q    <= shift_d;
            ptr_q      <= ptr_d;
            hi_q       <= hi_d;
            need_ptr_q <= need_ptr_d;
            lo_q       <= lo_d;
            rw_q       <= rw_d;
            nack_q     <= nack_d;
            word_q     <= word_d;
            oe_q       <= oe_d;
        end
    end

    // sda only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe  = oe_q;

    // ************************************************
    // interrupt pin and decoded outputs
    // ************************************************
    logic        irq_n_q, irq_n_d, irq_oe_q, irq_oe_d, irq_active, rsv_q, rsv_d;
    logic [14:0] irq_src;
    logic [7:0]  amp_q;
    logic [6:0]  bck_q;
    logic [5:0]  wl_q;
    logic [13:0] sr_q;

    always_comb begin
        irq_src    = sys_q.irq_pin_config_src ? live_status_reg : flags;
        irq_active = |(irq_src & ~mask_q[14:0]);
        if (sys_q.irq_pin_config_drive) begin
            irq_oe_d = 1'b1;
            irq_n_d  = ~irq_active;
        end else begin
            irq_oe_d = irq_active;
            irq_n_d  = 1'b0;
        end
        rsv_d = (sys_q.speaker_gain_sel == 3'h5) | (sys_q.speaker_gain_sel == 3'h7)
              | (aud_q.channel_pick == 2'h0) | (aud_q.frame_format == 2'h3)
              | (aud_q.bitclk_ratio == 2'h3) | (rate(aud_q.sample_rate_sel) == 14'h0000);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_n_q  <= 1'b0;
            irq_oe_q <= 1'b0;
            amp_q    <= 8'h00;
            bck_q    <= 7'h00;
            wl_q     <= 6'h00;
            sr_q     <= 14'h0000;
            rsv_q    <= 1'b0;
        end else begin
            irq_n_q  <= irq_n_d;
            irq_oe_q <= irq_oe_d;
            amp_q    <= amplitude(sys_q);
            bck_q    <= bck_ratio(aud_q.bitclk_ratio);
            wl_q     <= width_bits(aud_q.sample_width);
            sr_q     <= rate(aud_q.sample_rate_sel);
            rsv_q    <= rsv_d;
        end
    end

    assign system_control           = sys_q;
    assign audio_port_control       = aud_q;
    assign irq_out_n                = irq_n_q;
    assign irq_out_n_oe             = irq_oe_q;
    assign nominal_output_amplitude = amp_q;
    assign bitclk_per_frame         = bck_q;
    assign word_length              = wl_q;
    assign sample_rate_10hz         = sr_q;
    assign config_reserved          = rsv_q;

endmodule // amp_irq_and_audio_port_config
`default_nettype wire

// ===== design/irq_flag_bank.sv
// sticky change flags for the fifteen status sources
// assumes: status comes from logic on sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "amp_cfg_map.svh"
module irq_flag_bank (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [14:0] status,
    input  wire logic        clr_en,
    input  wire logic [14:0] clr_mask,
    output logic      [14:0] flags
);
    logic [14:0] flags_q;
    logic [14:0] flags_d;
    logic [14:0] prev_q;
    logic        primed_q;
    logic [14:0] change;

    // no compare in the first cycle: prev is not yet valid
    always_comb begin
        change  = primed_q ? (status ^ prev_q) : 15'h0000;
        flags_d = flags_q;
        if (clr_en) begin
            flags_d = flags_q & ~clr_mask;
        end
        flags_d = flags_d | change;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flags_q  <= `FLAGS_RESET;
            prev_q   <= 15'h0000;
            primed_q <= 1'b0;
        end else begin
            flags_q  <= flags_d;
            prev_q   <= status;
            primed_q <= 1'b1;
        end
    end

    assign flags = flags_q;
endmodule // irq_flag_bank
`default_nettype wire

// ===== design/pin_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes: pins idle high, as on a two-wire bus
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] lvl_q;
    logic [WIDTH-1:0] lvl_d;
    logic [WIDTH-1:0] agree;

    // first stage feeds only the second
    always_comb begin
        agree = ~(s2_q ^ s3_q);
        lvl_d = (s3_q & agree) | (lvl_q & ~agree);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s1_q  <= '1;
            s2_q  <= '1;
            s3_q  <= '1;
            lvl_q <= '1;
        end else begin
            s1_q  <= pin;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level = lvl_q;
endmodule // pin_sync
`default_nettype wire

// ===== inc/amp_cfg_map.svh
// register offsets, reset values, write masks and decode constants
// assumes: included by bare name from the design files
`ifndef AMP_CFG_MAP_SVH
`define AMP_CFG_MAP_SVH

`define REG_FLAGS      8'h02
`define REG_MASKS      8'h03
`define REG_SYSTEM_CONTROL    8'h04
`define REG_AUDIO      8'h05

`define FLAGS_RESET    15'h4000
`define MASK_RESET     16'hffff
`define MASK_WMASK     16'h7fff
`define MASK_FIXED     16'h8000
`define SYS_RESET      16'h6007
`define SYS_WMASK      16'h7ffb
`define SYS_FIXED      16'h0004
`define AUD_RESET      16'h04e8
`define AUD_WMASK      16'h2fff
`define AUD_FIXED      16'h0000

`define DEV_ADDR_DFLT  7'h34
`define RX_LAST        4'h8
`define TX_LAST        4'h7

`define AMP_7          8'h46
`define AMP_8          8'h50
`define AMP_10         8'h64
`define AMP_12         8'h78
`define AMP_14         8'h8c
`define AMP_16         8'ha0
`define AMP_4P5        8'h2d
`define AMP_5          8'h32
`define AMP_5P5        8'h37

`define BCK_32         7'h20
`define BCK_48         7'h30
`define BCK_64         7'h40
`define WL_16          6'h10
`define WL_20          6'h14
`define WL_24          6'h18
`define WL_32          6'h20

`define SR_22K05       14'h089d
`define SR_24K         14'h0960
`define SR_32K         14'h0c80
`define SR_44K1        14'h113a
`define SR_48K         14'h12c0
`define SR_96K         14'h2580

`endif

// ===== inc/amp_cfg_pkg.sv
// types shared by the configuration block and its users
// assumes: nothing beyond a SystemVerilog compiler
package amp_cfg_pkg;

    typedef struct packed {
        logic       rsvd_15;
        logic [2:0] speaker_gain_sel;
        logic [1:0] earpiece_gain_sel;
        logic       irq_pin_config_drive;
        logic       irq_pin_config_src;
        logic       earpiece_mode;
        logic       audio_port_enable;
        logic       channel_swap;
        logic       bitclk_invert;
        logic       pll_ref_sel;
        logic       rsvd_2;
        logic       amp_powerdown;
        logic       system_powerdown;
    } system_control_t;

    typedef struct packed {
        logic [1:0] rsvd_15_14;
        logic       input_attenuate;
        logic       rsvd_12;
        logic [1:0] channel_pick;
        logic [1:0] frame_format;
        logic [1:0] sample_width;
        logic [1:0] bitclk_ratio;
        logic [3:0] sample_rate_sel;
    } audio_port_control_t;

    typedef enum logic [6:0] {
        ST_IDLE     = 7'h01,
        ST_ADDR     = 7'h02,
        ST_ADDR_ACK = 7'h04,
        ST_RX       = 7'h08,
        ST_RX_ACK   = 7'h10,
        ST_TX       = 7'h20,
        ST_TX_ACK   = 7'h40
    } link_state_t;

endpackage

// ===== tb/amp_cfg_host.sv
// two-wire bus master in place of the host processor
// assumes: sda resolved outside with pull-up; drives at falling edges
`timescale 1ns/1ps
`default_nettype none
`include "amp_cfg_map.svh"
module amp_cfg_host #(
    parameter int Q = 40
) (
    input  wire logic        sys_clk,
    input  wire logic        sda,
    output logic             scl,
    output logic             sda_low,
    output logic             rd_stb,
    output logic [15:0]      rd_word
);
    // ****
    // bit, byte and transfer level
    // ****
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        rd_stb = 1'b0;
        rd_word = 16'h0;
    end
    task automatic q();
        repeat (Q) @(negedge sys_clk);
    endtask
    // data changes only while scl low, a quarter after the fall
    task automatic bit_io(input logic b, output logic s);
        sda_low = !b;
        q();
        scl = 1'b1;
        q();
        s = sda;
        q();
        scl = 1'b0;
        q();
    endtask
    task automatic byte_io(input logic [7:0] d, input logic ack, output logic [7:0] r);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(!ack, s);
    endtask
    task automatic wr(input logic [7:0] p, input int n, input logic [47:0] d);
        logic [7:0] r;
        sda_low = 1'b1;
        q();
        scl = 1'b0;
        byte_io({`DEV_ADDR_DFLT, 1'b0}, 1'b0, r);
        byte_io(p, 1'b0, r);
        for (int i = 0; i < 2 * n; i++) begin
            byte_io(d[47 - 8 * i -: 8], 1'b0, r);
        end
        stop();
    endtask
    task automatic rd(input int n);
        logic [7:0] r;
        logic [7:0] h;
        sda_low = 1'b1;
        q();
        scl = 1'b0;
        byte_io({`DEV_ADDR_DFLT, 1'b1}, 1'b0, r);
        for (int i = 0; i < n; i++) begin
            byte_io(8'hff, 1'b1, h);
            byte_io(8'hff, i < n - 1, r);
            rd_word = {h, r};
            rd_stb = 1'b1;
            @(negedge sys_clk);
            rd_stb = 1'b0;
        end
        stop();
    endtask
    task automatic stop();
        sda_low = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b0;
        q();
    endtask
endmodule // amp_cfg_host
`default_nettype wire

// ===== tb/amp_cfg_properties.sv
// checker on the configuration block ports
// assumes: bound into the top module; sync reset
`timescale 1ns/1ps
`default_nettype none
module amp_cfg_properties (
    input wire logic                             sys_clk,
    input wire logic                             rst,
    input wire logic [14:0]                      live_status_reg,
    input wire logic                             irq_out_n,
    input wire logic                             irq_out_n_oe,
    input wire amp_cfg_pkg::system_control_t     system_control,
    input wire amp_cfg_pkg::audio_port_control_t audio_port_control,
    input wire logic [6:0]                       bitclk_per_frame
);
    import amp_cfg_pkg::*;
    // ****
    // properties
    // ****
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_rst_val;
        disable iff (1'b0) rst |=> system_control == 16'h6007 && audio_port_control == 16'h04e8;
    endproperty
    a_rst_val: assert property (p_rst_val)
        else $error("bad reset value");
    property p_rsvd;
        !system_control[15] && system_control[2] && (audio_port_control & 16'hd000) == 16'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit moved");
    property p_pp;
        system_control.irq_pin_config_drive |=> irq_out_n_oe;
    endproperty
    a_pp: assert property (p_pp) else $error("push-pull not driven");
    property p_od;
        !system_control.irq_pin_config_drive |=> !irq_out_n;
    endproperty
    a_od: assert property (p_od) else $error("open-drain drives high");
    property p_wired;
        irq_out_n |-> irq_out_n_oe;
    endproperty
    a_wired: assert property (p_wired) else $error("high level undriven");
    // live source idle means pin idle, whatever the mask
    property p_idle;
        system_control.irq_pin_config_src && live_status_reg == 15'h0 |=> irq_out_n == irq_out_n_oe;
    endproperty
    a_idle: assert property (p_idle) else $error("irq without live status");
    property p_boot;
        $fell(rst) |-> !irq_out_n_oe [*3];
    endproperty
    a_boot: assert property (p_boot) else $error("irq after reset");
    property p_bck;
        1'b1 |=> bitclk_per_frame == ($past(audio_port_control.bitclk_ratio) == 2'h3 ?
            7'h00 : 7'h20 + 7'h10 * $past(audio_port_control.bitclk_ratio));
    endproperty
    a_bck: assert property (p_bck) else $error("bit clock ratio");
endmodule // amp_cfg_properties
bind amp_irq_and_audio_port_config amp_cfg_properties i_amp_cfg_properties (.sys_clk, .rst,
    .live_status_reg, .irq_out_n, .irq_out_n_oe, .system_control, .audio_port_control,
    .bitclk_per_frame);
`default_nettype wire

// ===== tb/amp_irq_and_audio_port_config_tb.sv
// self-checking bench for the configuration block
// assumes: host model on the bus pins; status driven here
`timescale 1ns/1ps
`default_nettype none
module amp_irq_and_audio_port_config_tb;
    import amp_cfg_pkg::*;
    logic        sys_clk, rst, scl, sda_low, rd_stb, sda_oe, irq_out_n, irq_out_n_oe, cfg_rsv;
    logic [14:0] live_status_reg;
    logic [13:0] srt;
    logic [7:0]  amp;
    logic [5:0]  wl;
    logic [15:0] rd_word, sc, au, exp_q[$];
    int          err_count, comparisons, r;
    wire         sda = !(sda_low | sda_oe);
    amp_irq_and_audio_port_config i_amp_irq_and_audio_port_config (.sys_clk, .rst,
        .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe, .live_status_reg, .irq_out_n,
        .irq_out_n_oe, .system_control(), .audio_port_control(), .nominal_output_amplitude(amp),
        .bitclk_per_frame(), .word_length(wl), .sample_rate_10hz(srt), .config_reserved(cfg_rsv));
    amp_cfg_host i_amp_cfg_host (.sys_clk, .sda, .scl, .sda_low, .rd_stb, .rd_word);
    // ****
    // checking
    // ****
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        if (rd_stb === 1'b1) begin
            check("read word", rd_word, exp_q.pop_front());
        end
    end
    // pointer at flags, then five words: four registers and one unmapped
    task automatic rd_regs(input logic [15:0] f, input logic [15:0] m, input logic [15:0] s,
                           input logic [15:0] a);
        exp_q = '{f, m, s, a, 16'h0};
        i_amp_cfg_host.wr(8'h02, 0, 48'h0);
        i_amp_cfg_host.rd(5);
        $display("readback done");
    endtask
    task automatic wait_irq(input logic lvl);
        int k;
        for (k = 0; k < 20 && irq_out_n !== lvl; k++) begin
            @(negedge sys_clk);
        end
        check("irq_out_n", {15'h0, irq_out_n}, {15'h0, lvl});
        $display("irq step done");
        if (k == 20) begin
            report_and_stop();
        end
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        rst = 1'b1;
        live_status_reg = 15'h0;
        err_count = 0;
        comparisons = 0;
        r = $urandom(32'h8f7d8e46);
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        repeat (8) @(negedge sys_clk);
        check("decodes", {amp, 1'b0, cfg_rsv, wl}, {8'ha0, 2'b00, 6'h20});
        check("rate", {2'b00, srt}, 16'h12c0);
        rd_regs(16'h4000, 16'hffff, 16'h6007, 16'h04e8);
        sc = 16'($urandom) & 16'hfcff | 16'h0200;
        au = 16'($urandom);
        i_amp_cfg_host.wr(8'h03, 3, {16'h0000, sc, au});
        wait_irq(1'b1);
        r = $urandom_range(14, 0);
        live_status_reg = 15'h1 << r;
        wait_irq(1'b0);
        rd_regs(16'h1 << r, 16'h8000, sc & 16'h7ffb | 16'h0004, au & 16'h2fff);
        wait_irq(1'b1);
        i_amp_cfg_host.wr(8'h04, 1, {sc | 16'h0100, 32'h0});
        wait_irq(1'b0);
        i_amp_cfg_host.wr(8'h03, 1, {16'hffff, 32'h0});
        wait_irq(1'b1);
        live_status_reg = 15'h0;
        repeat (4) @(negedge sys_clk);
        report_and_stop();
    end
endmodule // amp_irq_and_audio_port_config_tb
`default_nettype wire
